/* bench/bmmsel_chk.sv */
// Concurrent checks on the ports of the boot mode and program map selector.
`timescale 1ns/1ns
`default_nettype none
module bmmsel_chk
  import bmmsel_pkg::*;
(
  // Clock and reset
  input wire logic CLOCK_IN,
  input wire logic RST_IN,
  // Mode results
  input wire logic EFF_MAP_EXT_OUT,
  input wire logic BOOT_EXTERNAL_OUT,
  input wire logic EXT_ADDR_WIDE_OUT,
  input wire logic FLASH_SECURE_OUT,
  input wire logic EXT_PSPACE_EN_OUT,
  input wire logic DEBUG_PORT_EN_OUT,
  input wire logic [PADDR_W-1:0] RESET_VECTOR_OUT,
  input wire logic [PADDR_W-1:0] WDOG_VECTOR_OUT,
  // Flash paths
  input wire logic CORE_RD_REQ_IN,
  input wire logic CORE_RD_GNT_OUT,
  input wire logic SBUS_RD_GNT_OUT,
  input wire logic FIU_WR_REQ_IN,
  input wire logic FIU_WR_WORD_IN,
  input wire logic FIU_WR_CORE_IN,
  input wire logic FLASH_PGM_STB_OUT
);
  logic pgm_ok;
  assign pgm_ok = FIU_WR_REQ_IN && FIU_WR_WORD_IN && FIU_WR_CORE_IN;
  default clocking mode_cb @(posedge CLOCK_IN);
  endclocking
  default disable iff (RST_IN);
  grant_excl_a: assert property (!(CORE_RD_GNT_OUT && SBUS_RD_GNT_OUT))
    else $error("both flash read grants high");
  core_grant_a: assert property (CORE_RD_REQ_IN && !CORE_RD_GNT_OUT && !SBUS_RD_GNT_OUT |=> CORE_RD_GNT_OUT)
    else $error("idle core read request not granted");
  pgm_strobe_a: assert property (pgm_ok |=> FLASH_PGM_STB_OUT)
    else $error("accepted program request gave no strobe");
  pgm_cause_a: assert property (FLASH_PGM_STB_OUT |-> $past(pgm_ok))
    else $error("program strobe without a word write request");
  debug_lock_a: assert property (DEBUG_PORT_EN_OUT == !FLASH_SECURE_OUT && EXT_PSPACE_EN_OUT == !FLASH_SECURE_OUT)
    else $error("debug or external space enabled while secured");
  map_gate_a: assert property (EFF_MAP_EXT_OUT |-> !FLASH_SECURE_OUT)
    else $error("external map selected while secured");
  sec_hold_a: assert property (!$past(RST_IN) && !$past(RST_IN, 2) |-> $stable(FLASH_SECURE_OUT))
    else $error("security state changed outside reset");
  boot_fixed_a: assert property (!BOOT_EXTERNAL_OUT && !EXT_ADDR_WIDE_OUT)
    else $error("external boot or wide bus seen");
  vectors_a: assert property (RESET_VECTOR_OUT == VEC_INT_BOOT && WDOG_VECTOR_OUT == VEC_INT_WDOG)
    else $error("boot vectors not internal");
  cover property ($fell(CORE_RD_GNT_OUT) ##[0:2] SBUS_RD_GNT_OUT);
  cover property (FLASH_PGM_STB_OUT);
  cover property (EFF_MAP_EXT_OUT);
endmodule
`default_nettype wire

/* bench/bmmsel_flash_bus_model.sv */
// Behavioural model of the two buses that read data flash.
`timescale 1ns/1ns
`default_nettype none
module bmmsel_flash_bus_model
#(
  parameter int HOLD = 4
)
(
  // Clock
  input wire logic clk_in,
  // Start pulses, bit 0 core read bus, bit 1 secondary bus
  input wire logic [1:0] go_in,
  // Grants and requests
  input wire logic [1:0] gnt_in,
  output logic [1:0] req_out
);
  int cnt_ff [2];
  initial req_out = 2'h0;
  // A waiting bus keeps its request up, so a late grant is still used in full.
  always @(posedge clk_in)
  begin
    for (int i = 0; i < 2; i++)
    begin
      if (go_in[i])
      begin
        req_out[i] <= 1'b1;
        cnt_ff[i] <= 0;
      end
      else if (req_out[i] && gnt_in[i])
      begin
        cnt_ff[i] <= cnt_ff[i] + 1;
        if (cnt_ff[i] == HOLD - 1)
          req_out[i] <= 1'b0;
      end
    end
  end
endmodule
`default_nettype wire

/* bench/bmmsel_tb.sv */
// Self-checking bench for the boot mode and program map selector.
`timescale 1ns/1ns
`default_nettype none
module bmmsel_tb
  import bmmsel_pkg::*;
;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic boot_pin = 1'b1;
  logic wide_pin = 1'b1;
  logic fsec = 1'b1;
  logic [PADDR_W-1:0] paddr = 21'h0;
  bmm_region_e region;
  logic eff_map, boot_ext, wide, secure, pspace, dbg, stb;
  logic [PADDR_W-1:0] rvec, wvec;
  logic [1:0] go = 2'h0;
  logic [1:0] req, gnt;
  logic fiu_req = 1'b0, fiu_word = 1'b0, fiu_core = 1'b0;
  logic [3:0] wstrb = 4'hf;
  logic [7:0] awaddr = 8'h0, araddr = 8'h0;
  logic [31:0] wdata = 32'h0;
  logic awv = 1'b0, wv = 1'b0, bready = 1'b0, arv = 1'b0, rready = 1'b0;
  logic awrdy, wrdy, bv, arrdy, rv;
  logic [1:0] bresp, rresp;
  logic [31:0] rdata;
  logic [20:0] pa [5] = '{21'h0, 21'h20000, 21'h2f800, 21'h8000, 21'h18000};
  bmm_region_e rg [5] = '{RGN_PFLASH, RGN_BOOT, RGN_PRAM, RGN_RSVD, RGN_EXT};
  int fail_count = 0;
  int cmp_count = 0;

  always #5 clk = ~clk;

  bmmsel_top bmmsel_top_i (.CLOCK_IN(clk), .RST_IN(rst), .EXTERNAL_BOOT_PIN_IN(boot_pin),
    .EXT_MEM_WIDTH_PIN_IN(wide_pin), .FLASH_SECURED_IN(fsec), .PADDR_IN(paddr), .PREGION_OUT(region),
    .EFF_MAP_EXT_OUT(eff_map), .BOOT_EXTERNAL_OUT(boot_ext), .EXT_ADDR_WIDE_OUT(wide),
    .FLASH_SECURE_OUT(secure), .EXT_PSPACE_EN_OUT(pspace), .DEBUG_PORT_EN_OUT(dbg),
    .RESET_VECTOR_OUT(rvec), .WDOG_VECTOR_OUT(wvec), .CORE_RD_REQ_IN(req[0]), .SBUS_RD_REQ_IN(req[1]),
    .CORE_RD_GNT_OUT(gnt[0]), .SBUS_RD_GNT_OUT(gnt[1]), .FIU_WR_REQ_IN(fiu_req), .FIU_WR_WORD_IN(fiu_word),
    .FIU_WR_CORE_IN(fiu_core), .FLASH_PGM_STB_OUT(stb), .S_AXI_AWADDR_IN(awaddr), .S_AXI_AWVALID_IN(awv),
    .S_AXI_AWREADY_OUT(awrdy), .S_AXI_WDATA_IN(wdata), .S_AXI_WSTRB_IN(wstrb), .S_AXI_WVALID_IN(wv),
    .S_AXI_WREADY_OUT(wrdy), .S_AXI_BRESP_OUT(bresp), .S_AXI_BVALID_OUT(bv), .S_AXI_BREADY_IN(bready),
    .S_AXI_ARADDR_IN(araddr), .S_AXI_ARVALID_IN(arv), .S_AXI_ARREADY_OUT(arrdy), .S_AXI_RDATA_OUT(rdata),
    .S_AXI_RRESP_OUT(rresp), .S_AXI_RVALID_OUT(rv), .S_AXI_RREADY_IN(rready));

  bmmsel_flash_bus_model #(.HOLD(4)) bmmsel_flash_bus_model_i (.clk_in(clk), .go_in(go), .gnt_in(gnt),
    .req_out(req));

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp)
    begin
      fail_count++;
      $display("MISMATCH at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
    int n;
    @(posedge clk);
    awaddr <= a;
    wdata <= d;
    awv <= 1'b1;
    wv <= 1'b1;
    bready <= 1'b1;
    n = 0;
    do
    begin
      @(posedge clk);
      n++;
      if (awrdy) awv <= 1'b0;
      if (wrdy) wv <= 1'b0;
    end
    while (bv !== 1'b1 && n < 50);
    bready <= 1'b0;
    if (bv !== 1'b1)
      fail_count++;
    chk(bresp, er);
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] exp, input logic [1:0] er);
    int n;
    @(posedge clk);
    araddr <= a;
    arv <= 1'b1;
    rready <= 1'b1;
    n = 0;
    do
    begin
      @(posedge clk);
      n++;
      if (arrdy) arv <= 1'b0;
    end
    while (rv !== 1'b1 && n < 50);
    rready <= 1'b0;
    if (rv !== 1'b1)
      fail_count++;
    chk(rdata, exp);
    chk(rresp, er);
  endtask

  // Capture happens on the first edge after release, so requests start two edges later.
  task automatic do_reset(input logic sec);
    fsec <= sec;
    rst <= 1'b1;
    repeat (8) @(posedge clk);
    rst <= 1'b0;
    repeat (2) @(posedge clk);
  endtask

  task automatic pgm(input logic w, input logic c, input logic e);
    @(posedge clk);
    fiu_req <= 1'b1;
    fiu_word <= w;
    fiu_core <= c;
    @(posedge clk);
    fiu_req <= 1'b0;
    @(negedge clk);
    chk(stb, e);
  endtask

  task automatic wait_gnt(input logic [1:0] e);
    int n;
    n = 0;
    while (gnt !== e && n < 20)
    begin
      @(posedge clk);
      n++;
    end
    chk(gnt, e);
  endtask

  task automatic end_of_test();
    $display("comparisons %0d mismatches %0d", cmp_count, fail_count);
    if (fail_count == 0 && cmp_count > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask

  initial
  begin
    #100000;
    fail_count++;
    end_of_test();
  end

  initial
  begin
    do_reset(1'b1);
    chk(secure, 1'b1);
    chk(dbg, 1'b0);
    chk(pspace, 1'b0);
    chk(boot_ext, 1'b0);
    chk(wide, 1'b0);
    chk(rvec, VEC_INT_BOOT);
    chk(wvec, VEC_INT_WDOG);
    rd(OFS_OPMODE, 32'h0, RESP_OKAY);
    wr(OFS_OPMODE, 32'h1, RESP_OKAY);
    chk(eff_map, 1'b0);
    rd(OFS_OPMODE, 32'h1, RESP_OKAY);
    rd(OFS_STATUS, 32'h8, RESP_OKAY);
    fsec <= 1'b0;
    repeat (3) @(posedge clk);
    chk(secure, 1'b1);
    $display("test secured boot done");
    do_reset(1'b0);
    chk(secure, 1'b0);
    chk(dbg, 1'b1);
    rd(OFS_OPMODE, 32'h2, RESP_OKAY);
    rd(OFS_STATUS, 32'h32, RESP_OKAY);
    wr(OFS_OPMODE, 32'h3, RESP_OKAY);
    chk(eff_map, 1'b1);
    wr(OFS_OPMODE, 32'h1, RESP_OKAY);
    chk(secure, 1'b0);
    chk(eff_map, 1'b1);
    wr(OFS_OPMODE, 32'h0, RESP_OKAY);
    chk(eff_map, 1'b0);
    wstrb <= 4'he;
    wr(OFS_OPMODE, 32'h3, RESP_OKAY);
    rd(OFS_OPMODE, 32'h0, RESP_OKAY);
    chk(eff_map, 1'b0);
    wstrb <= 4'hf;
    $display("test unsecured map switch done");
    foreach (pa[i])
    begin
      @(posedge clk);
      paddr <= pa[i];
      @(negedge clk);
      chk(region, rg[i]);
    end
    rd(OFS_CONFIG, 32'h0c080840, RESP_OKAY);
    wr(OFS_STATUS, 32'hffffffff, RESP_OKAY);
    rd(OFS_STATUS, 32'h32, RESP_OKAY);
    rd(8'h10, 32'h0, RESP_SLVERR);
    wr(8'h10, 32'h1, RESP_SLVERR);
    $display("test decode and registers done");
    pgm(1'b1, 1'b1, 1'b1);
    pgm(1'b0, 1'b1, 1'b0);
    pgm(1'b1, 1'b0, 1'b0);
    rd(OFS_FLASHIF, 32'h200, RESP_OKAY);
    $display("test flash program done");
    @(posedge clk);
    go <= 2'h3;
    @(posedge clk);
    go <= 2'h0;
    repeat (2) @(posedge clk);
    chk(gnt, 2'h1);
    wait_gnt(2'h2);
    wait_gnt(2'h0);
    $display("test flash read paths done");
    end_of_test();
  end
endmodule

bind bmmsel_top bmmsel_chk bmmsel_chk_i (.CLOCK_IN(CLOCK_IN), .RST_IN(RST_IN), .EFF_MAP_EXT_OUT(EFF_MAP_EXT_OUT),
  .BOOT_EXTERNAL_OUT(BOOT_EXTERNAL_OUT), .EXT_ADDR_WIDE_OUT(EXT_ADDR_WIDE_OUT), .FLASH_SECURE_OUT(FLASH_SECURE_OUT),
  .EXT_PSPACE_EN_OUT(EXT_PSPACE_EN_OUT), .DEBUG_PORT_EN_OUT(DEBUG_PORT_EN_OUT), .RESET_VECTOR_OUT(RESET_VECTOR_OUT),
  .WDOG_VECTOR_OUT(WDOG_VECTOR_OUT), .CORE_RD_REQ_IN(CORE_RD_REQ_IN), .CORE_RD_GNT_OUT(CORE_RD_GNT_OUT),
  .SBUS_RD_GNT_OUT(SBUS_RD_GNT_OUT), .FIU_WR_REQ_IN(FIU_WR_REQ_IN), .FIU_WR_WORD_IN(FIU_WR_WORD_IN),
  .FIU_WR_CORE_IN(FIU_WR_CORE_IN), .FLASH_PGM_STB_OUT(FLASH_PGM_STB_OUT));
`default_nettype wire

/* hw/bmmsel_flash_rd_arb.sv */
// Arbiter giving the data flash read port to one bus at a time.
`timescale 1ns/1ns
`default_nettype none
module bmmsel_flash_rd_arb
  import bmmsel_pkg::*;
(
  // Clock and reset
  input wire logic clk_in,
  input wire logic rst_in,
  // Requests, held high for the whole access
  input wire logic core_req_in,
  input wire logic sec_req_in,
  // Grants
  output logic core_gnt_out,
  output logic sec_gnt_out
);

  typedef enum logic [1:0] {
    ARB_IDLE,
    ARB_CORE,
    ARB_SEC
  } bmm_arb_e;

  bmm_arb_e state_ff;
  bmm_arb_e nxt_state;

  // A grant is kept until its owner drops the request, so a long access is never cut.
  always_comb
  begin
    nxt_state = state_ff;
    case (state_ff)
      ARB_IDLE:
      begin
        if (core_req_in)
          nxt_state = ARB_CORE;
        else if (sec_req_in)
          nxt_state = ARB_SEC;
      end
      ARB_CORE:
      begin
        if (!core_req_in)
          nxt_state = sec_req_in ? ARB_SEC : ARB_IDLE;
      end
      ARB_SEC:
      begin
        if (!sec_req_in)
          nxt_state = core_req_in ? ARB_CORE : ARB_IDLE;
      end
      default:
        nxt_state = ARB_IDLE;
    endcase
  end

  always_ff @(posedge clk_in)
  begin
    if (rst_in)
      state_ff <= ARB_IDLE;
    else
      state_ff <= nxt_state;
  end

  assign core_gnt_out = (state_ff == ARB_CORE);
  assign sec_gnt_out = (state_ff == ARB_SEC);

endmodule
`default_nettype wire

/* hw/bmmsel_pkg.sv */
// Constants, types and register layout for the boot mode and program map selector.
//
// Overview of operation
// - Security-state mode bit is loaded only at reset; later flash changes wait for reset.
// - At reset, security bit follows flash secured state, map bit follows boot pin.
// - Both bits 0: internal boot, 16-bit bus, secured, no external space, no debug.
// - Security 0 with map 1 is invalid; the device falls back to the 00 state.
// - Security 1 with map 0: internal boot, external interface uses 16 address lines.
// - Both bits 1: external boot, unsecured; width pin picks the external interface width; the external reset vectors are used only with the wide width.
// - Software may write the map bit: 0 internal map, 1 external map.
// - If security bit was 0 at reset, software map changes do not alter the map.
// - Software writes of the security bit change neither map nor real flash security.
// - External boot and width inputs are treated as fixed at 0 on this part.
// - Data flash is read by core read bus or secondary bus, one at a time.
// - Flash erase and program only via flash interface with core write-bus word writes.
// - Sizes: 64KB program flash, 8KB data flash, 4KB program RAM, 8KB data RAM, 8KB boot.
// - Internal boot starts at program address 0 and watchdog resets to address 2.
`default_nettype none
package bmmsel_pkg;

  // ****************************************
  // Register map
  // ****************************************
  localparam logic [7:0] OFS_OPMODE = 8'h00;
  localparam logic [7:0] OFS_STATUS = 8'h04;
  localparam logic [7:0] OFS_CONFIG = 8'h08;
  localparam logic [7:0] OFS_FLASHIF = 8'h0c;
  localparam int ADDR_W = 8;

  localparam int OPM_MAP_BIT = 0;
  localparam int OPM_SEC_BIT = 1;

  localparam int ST_CAP_MAP = 0;
  localparam int ST_CAP_SEC = 1;
  localparam int ST_EFF_MAP = 2;
  localparam int ST_SECURED = 3;
  localparam int ST_DBG_EN = 4;
  localparam int ST_EXT_ALLOWED = 5;
  localparam int ST_EXT_WIDE = 6;
  localparam int ST_EXTERNAL_BOOT_INPUT = 7;
  localparam int ST_INVALID = 8;

  localparam int FI_GNT_CORE = 0;
  localparam int FI_GNT_SEC = 1;
  localparam int FI_REJ_LSB = 8;
  localparam int REJ_W = 8;

  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  localparam logic [31:0] OPMODE_RESET = 32'h0;

  // ****************************************
  // Memory sizes in kilobytes
  // ****************************************
  localparam logic [7:0] KB_PFLASH = 8'h40;
  localparam logic [7:0] KB_DFLASH = 8'h08;
  localparam logic [7:0] KB_PRAM = 8'h04;
  localparam logic [7:0] KB_DRAM = 8'h08;
  localparam logic [7:0] KB_BOOT = 8'h08;

  // ****************************************
  // Program space, word addresses
  // ****************************************
  localparam int PADDR_W = 21;
  localparam logic [20:0] VEC_INT_BOOT = 21'h000000;
  localparam logic [20:0] VEC_INT_WDOG = 21'h000002;
  localparam logic [20:0] VEC_EXTERNAL_BOOT_INPUT = 21'h020000;
  localparam logic [20:0] VEC_EXT_WDOG = 21'h020002;
  localparam logic [20:0] PM_LOW_FLASH_END = 21'h007fff;
  localparam logic [20:0] PM_LOW_EXT_END = 21'h00ffff;
  localparam logic [20:0] PM_HIGH_FLASH_LO = 21'h010000;
  localparam logic [20:0] PM_HIGH_FLASH_END = 21'h017fff;
  localparam logic [20:0] PM_XRAM_LO = 21'h018000;
  localparam logic [20:0] PM_XRAM_END = 21'h01ffff;
  localparam logic [20:0] PM_BOOT_LO = 21'h020000;
  localparam logic [20:0] PM_BOOT_END = 21'h020fff;
  localparam logic [20:0] PM_PRAM_LO = 21'h02f800;
  localparam logic [20:0] PM_PRAM_END = 21'h02ffff;
  localparam logic [20:0] PM_EXT_HI_LO = 21'h100000;

  typedef enum logic [2:0] {
    RGN_PFLASH,
    RGN_BOOT,
    RGN_PRAM,
    RGN_EXT,
    RGN_RSVD
  } bmm_region_e;

endpackage
`default_nettype wire

/* hw/bmmsel_top.sv */
// Boot mode capture, program map selection and flash access gating.
`timescale 1ns/1ns
`default_nettype none
module bmmsel_top
  import bmmsel_pkg::*;
#(
  parameter bit EXT_PINS_BONDED = 1'b0,
  parameter bit FULL_VARIANT = 1'b1
)
(
  // Clock and reset
  input wire logic CLOCK_IN,
  input wire logic RST_IN,
  // Boot straps and flash state
  input wire logic EXTERNAL_BOOT_PIN_IN,
  input wire logic EXT_MEM_WIDTH_PIN_IN,
  input wire logic FLASH_SECURED_IN,
  // Program address decode
  input wire logic [PADDR_W-1:0] PADDR_IN,
  output bmm_region_e PREGION_OUT,
  // Mode results
  output logic EFF_MAP_EXT_OUT,
  output logic BOOT_EXTERNAL_OUT,
  output logic EXT_ADDR_WIDE_OUT,
  output logic FLASH_SECURE_OUT,
  output logic EXT_PSPACE_EN_OUT,
  output logic DEBUG_PORT_EN_OUT,
  output logic [PADDR_W-1:0] RESET_VECTOR_OUT,
  output logic [PADDR_W-1:0] WDOG_VECTOR_OUT,
  // Data flash read paths
  input wire logic CORE_RD_REQ_IN,
  input wire logic SBUS_RD_REQ_IN,
  output logic CORE_RD_GNT_OUT,
  output logic SBUS_RD_GNT_OUT,
  // Flash erase and program requests
  input wire logic FIU_WR_REQ_IN,
  input wire logic FIU_WR_WORD_IN,
  input wire logic FIU_WR_CORE_IN,
  output logic FLASH_PGM_STB_OUT,
  // AXI4-Lite slave
  input wire logic [ADDR_W-1:0] S_AXI_AWADDR_IN,
  input wire logic S_AXI_AWVALID_IN,
  output logic S_AXI_AWREADY_OUT,
  input wire logic [31:0] S_AXI_WDATA_IN,
  input wire logic [3:0] S_AXI_WSTRB_IN,
  input wire logic S_AXI_WVALID_IN,
  output logic S_AXI_WREADY_OUT,
  output logic [1:0] S_AXI_BRESP_OUT,
  output logic S_AXI_BVALID_OUT,
  input wire logic S_AXI_BREADY_IN,
  input wire logic [ADDR_W-1:0] S_AXI_ARADDR_IN,
  input wire logic S_AXI_ARVALID_IN,
  output logic S_AXI_ARREADY_OUT,
  output logic [31:0] S_AXI_RDATA_OUT,
  output logic [1:0] S_AXI_RRESP_OUT,
  output logic S_AXI_RVALID_OUT,
  input wire logic S_AXI_RREADY_IN
);

  // ****************************************
  // Helpers
  // ****************************************
  function automatic logic in_range(input logic [PADDR_W-1:0] a, input logic [PADDR_W-1:0] lo,
                                    input logic [PADDR_W-1:0] hi);
    in_range = (a >= lo) && (a <= hi);
  endfunction

  function automatic logic is_mapped(input logic [ADDR_W-1:0] a);
    is_mapped = (a == OFS_OPMODE) || (a == OFS_STATUS) || (a == OFS_CONFIG) || (a == OFS_FLASHIF);
  endfunction

  // ****************************************
  // Strap synchronisers
  // ****************************************
  // Straps are sampled without reset so they are settled at the reset release edge.
  logic boot_s1_ff;
  logic boot_s2_ff;
  logic width_s1_ff;
  logic width_s2_ff;

  always_ff @(posedge CLOCK_IN)
  begin
    boot_s1_ff <= EXTERNAL_BOOT_PIN_IN;
    boot_s2_ff <= boot_s1_ff;
    width_s1_ff <= EXT_MEM_WIDTH_PIN_IN;
    width_s2_ff <= width_s1_ff;
  end

  // On this part the straps are not bonded out and read as 0.
  wire external_boot_input_v = EXT_PINS_BONDED & boot_s2_ff;
  wire ext_width_v = EXT_PINS_BONDED & width_s2_ff;

  // ****************************************
  // Mode capture at reset release
  // ****************************************
  logic rst_dly_ff;
  logic cap_sec_ff;
  logic cap_map_ff;
  logic cap_wide_ff;
  logic invalid_ff;

  wire capture = rst_dly_ff & ~RST_IN;
  wire sec_at_rst = ~FLASH_SECURED_IN;
  // Secured flash can never boot externally, so the map bit collapses to 0.
  wire map_at_rst = external_boot_input_v & sec_at_rst;

  always_ff @(posedge CLOCK_IN)
  begin
    if (RST_IN)
    begin
      rst_dly_ff <= 1'b1;
      cap_sec_ff <= 1'b0;
      cap_map_ff <= 1'b0;
      cap_wide_ff <= 1'b0;
      invalid_ff <= 1'b0;
    end
    else
    begin
      rst_dly_ff <= 1'b0;
      if (capture)
      begin
        cap_sec_ff <= sec_at_rst;
        cap_map_ff <= map_at_rst;
        cap_wide_ff <= map_at_rst & ext_width_v;
        invalid_ff <= external_boot_input_v & ~sec_at_rst;
      end
    end
  end

  // ****************************************
  // Operating mode register
  // ****************************************
  logic opm_map_ff;
  logic opm_sec_ff;

  // Write channel holding registers.
  logic aw_got_ff;
  logic w_got_ff;
  logic [ADDR_W-1:0] aw_addr_ff;
  logic [31:0] w_data_ff;
  logic [3:0] w_strb_ff;
  logic bvalid_ff;
  logic [1:0] bresp_ff;

  wire aw_hs = S_AXI_AWVALID_IN & S_AXI_AWREADY_OUT;
  wire w_hs = S_AXI_WVALID_IN & S_AXI_WREADY_OUT;
  wire wr_fire = aw_got_ff & w_got_ff & ~bvalid_ff;
  wire wr_opm = wr_fire & (aw_addr_ff == OFS_OPMODE) & w_strb_ff[0];

  // The captured values are loaded at release, after that only software changes them.
  always_ff @(posedge CLOCK_IN)
  begin
    if (RST_IN)
    begin
      opm_map_ff <= OPMODE_RESET[OPM_MAP_BIT];
      opm_sec_ff <= OPMODE_RESET[OPM_SEC_BIT];
    end
    else if (capture)
    begin
      opm_map_ff <= map_at_rst;
      opm_sec_ff <= sec_at_rst;
    end
    else if (wr_opm)
    begin
      opm_map_ff <= w_data_ff[OPM_MAP_BIT];
      opm_sec_ff <= w_data_ff[OPM_SEC_BIT];
    end
  end

  // ****************************************
  // Mode decode
  // ****************************************
  // The security bit in the register is only a scratch copy; real security uses the capture.
  wire eff_map = cap_sec_ff & opm_map_ff;
  wire secured = ~cap_sec_ff;
  wire ext_allowed = cap_sec_ff;
  wire boot_ext = cap_map_ff;
  wire wide = cap_wide_ff;

  assign EFF_MAP_EXT_OUT = eff_map;
  assign BOOT_EXTERNAL_OUT = boot_ext;
  assign EXT_ADDR_WIDE_OUT = wide;
  assign FLASH_SECURE_OUT = secured;
  assign EXT_PSPACE_EN_OUT = ext_allowed;
  assign DEBUG_PORT_EN_OUT = ~secured;
  assign RESET_VECTOR_OUT = (boot_ext & wide) ? VEC_EXTERNAL_BOOT_INPUT : VEC_INT_BOOT;
  assign WDOG_VECTOR_OUT = (boot_ext & wide) ? VEC_EXT_WDOG : VEC_INT_WDOG;

  // ****************************************
  // Program space decode
  // ****************************************
  wire a_lo_flash = in_range(PADDR_IN, VEC_INT_BOOT, PM_LOW_FLASH_END);
  wire a_lo_ext = in_range(PADDR_IN, VEC_INT_BOOT, PM_LOW_EXT_END);
  wire a_hi_flash = in_range(PADDR_IN, PM_HIGH_FLASH_LO, PM_HIGH_FLASH_END);
  wire a_xram = in_range(PADDR_IN, PM_XRAM_LO, PM_XRAM_END);
  wire a_boot = in_range(PADDR_IN, PM_BOOT_LO, PM_BOOT_END);
  wire a_pram = in_range(PADDR_IN, PM_PRAM_LO, PM_PRAM_END) & FULL_VARIANT;
  wire a_ext_hi = (PADDR_IN >= PM_EXT_HI_LO);
  // External regions turn into holes while external space is forbidden.
  wire a_ext = ext_allowed & (a_ext_hi | (eff_map ? a_lo_ext : a_xram));
  wire a_flash = eff_map ? a_hi_flash : a_lo_flash;

  assign PREGION_OUT = a_flash ? RGN_PFLASH :
                       a_boot ? RGN_BOOT :
                       a_pram ? RGN_PRAM :
                       a_ext ? RGN_EXT : RGN_RSVD;

  // ****************************************
  // Flash access paths
  // ****************************************
  logic pgm_stb_ff;
  logic [REJ_W-1:0] rej_cnt_ff;

  bmmsel_flash_rd_arb bmmsel_flash_rd_arb_i (
    .clk_in(CLOCK_IN),
    .rst_in(RST_IN),
    .core_req_in(CORE_RD_REQ_IN & FULL_VARIANT),
    .sec_req_in(SBUS_RD_REQ_IN & FULL_VARIANT),
    .core_gnt_out(CORE_RD_GNT_OUT),
    .sec_gnt_out(SBUS_RD_GNT_OUT)
  );

  wire pgm_ok = FIU_WR_REQ_IN & FIU_WR_WORD_IN & FIU_WR_CORE_IN;
  wire pgm_bad = FIU_WR_REQ_IN & ~pgm_ok;
  wire rej_full = &rej_cnt_ff;

  // The reject counter saturates so software never sees a wrap to zero.
  always_ff @(posedge CLOCK_IN)
  begin
    if (RST_IN)
    begin
      pgm_stb_ff <= 1'b0;
      rej_cnt_ff <= '0;
    end
    else
    begin
      pgm_stb_ff <= pgm_ok;
      if (pgm_bad & ~rej_full)
        rej_cnt_ff <= rej_cnt_ff + 1'b1;
    end
  end

  assign FLASH_PGM_STB_OUT = pgm_stb_ff;

  // ****************************************
  // Register read data
  // ****************************************
  wire [31:0] rd_opm = {30'h0, opm_sec_ff, opm_map_ff};
  wire [31:0] rd_status = {23'h0, invalid_ff, boot_ext, wide, ext_allowed, ~secured,
                           secured, eff_map, cap_sec_ff, cap_map_ff};
  wire [7:0] kb_df = FULL_VARIANT ? KB_DFLASH : 8'h00;
  wire [7:0] kb_pr = FULL_VARIANT ? KB_PRAM : 8'h00;
  wire [31:0] rd_config = {kb_pr, kb_df, KB_BOOT, KB_PFLASH};
  wire [31:0] rd_flashif = {{(32-REJ_W-FI_REJ_LSB){1'b0}}, rej_cnt_ff, 6'h0, SBUS_RD_GNT_OUT, CORE_RD_GNT_OUT};
  wire [ADDR_W-1:0] ra = S_AXI_ARADDR_IN;
  wire [31:0] rd_mux = (ra == OFS_OPMODE) ? rd_opm :
                       (ra == OFS_STATUS) ? rd_status :
                       (ra == OFS_CONFIG) ? {KB_DRAM, 24'h0} | rd_config :
                       (ra == OFS_FLASHIF) ? rd_flashif : 32'h0;

  // ****************************************
  // AXI4-Lite write channel
  // ****************************************
  assign S_AXI_AWREADY_OUT = ~aw_got_ff;
  assign S_AXI_WREADY_OUT = ~w_got_ff;

  always_ff @(posedge CLOCK_IN)
  begin
    if (RST_IN)
    begin
      aw_got_ff <= 1'b0;
      w_got_ff <= 1'b0;
      aw_addr_ff <= '0;
      w_data_ff <= '0;
      w_strb_ff <= '0;
      bvalid_ff <= 1'b0;
      bresp_ff <= RESP_OKAY;
    end
    else
    begin
      if (aw_hs)
      begin
        aw_got_ff <= 1'b1;
        aw_addr_ff <= S_AXI_AWADDR_IN;
      end
      if (w_hs)
      begin
        w_got_ff <= 1'b1;
        w_data_ff <= S_AXI_WDATA_IN;
        w_strb_ff <= S_AXI_WSTRB_IN;
      end
      if (wr_fire)
      begin
        bvalid_ff <= 1'b1;
        bresp_ff <= is_mapped(aw_addr_ff) ? RESP_OKAY : RESP_SLVERR;
      end
      else if (bvalid_ff & S_AXI_BREADY_IN)
      begin
        bvalid_ff <= 1'b0;
        aw_got_ff <= 1'b0;
        w_got_ff <= 1'b0;
      end
    end
  end

  assign S_AXI_BVALID_OUT = bvalid_ff;
  assign S_AXI_BRESP_OUT = bresp_ff;

  // ****************************************
  // AXI4-Lite read channel
  // ****************************************
  logic rvalid_ff;
  logic [31:0] rdata_ff;
  logic [1:0] rresp_ff;

  assign S_AXI_ARREADY_OUT = ~rvalid_ff;

  always_ff @(posedge CLOCK_IN)
  begin
    if (RST_IN)
    begin
      rvalid_ff <= 1'b0;
      rdata_ff <= '0;
      rresp_ff <= RESP_OKAY;
    end
    else if (S_AXI_ARVALID_IN & ~rvalid_ff)
    begin
      rvalid_ff <= 1'b1;
      rdata_ff <= rd_mux;
      rresp_ff <= is_mapped(ra) ? RESP_OKAY : RESP_SLVERR;
    end
    else if (rvalid_ff & S_AXI_RREADY_IN)
      rvalid_ff <= 1'b0;
  end

  assign S_AXI_RVALID_OUT = rvalid_ff;
  assign S_AXI_RDATA_OUT = rdata_ff;
  assign S_AXI_RRESP_OUT = rresp_ff;

endmodule
`default_nettype wire
